// [isf_pkg.sv]
// Package for the bus status and queue level block.
// Assumes an APB master with 32-bit data and word-aligned register offsets.
package isf_pkg;

   // Register byte offsets.
   localparam logic [7:0] BUS_STATUS_OFS     = 8'h70;
   localparam logic [7:0] TX_LEVEL_OFS       = 8'h74;
   localparam logic [7:0] RX_LEVEL_OFS       = 8'h78;
   localparam logic [7:0] CTRL_OFS           = 8'h90;
   localparam logic [7:0] EVENT_STATUS_OFS   = 8'h94;
   localparam logic [7:0] EVENT_MASK_OFS     = 8'h98;

   // Reset values.
   localparam logic [31:0] BUS_STATUS_RST    = 32'h0000_0006;
   localparam logic [31:0] LEVEL_RST         = 32'h0000_0000;
   localparam logic [1:0]  CTRL_RST          = 2'h0;
   localparam logic [4:0]  EVENT_RST         = 5'h00;

   // Queue geometry: a three-bit count holds up to the depth.
   localparam int          COUNT_W           = 3;
   localparam logic [2:0]  QUEUE_DEPTH       = 3'h4;

   // Bus status field positions.
   localparam int ST_ACTIVITY                = 0;
   localparam int ST_TX_NOT_FULL             = 1;
   localparam int ST_TX_EMPTY                = 2;
   localparam int ST_RX_NONEMPTY             = 3;
   localparam int ST_RX_FULL                 = 4;
   localparam int ST_MASTER_BUSY             = 5;
   localparam int ST_SLAVE_BUSY              = 6;
   localparam int ST_MASTER_STALL_TX         = 7;
   localparam int ST_MASTER_STALL_RX         = 8;
   localparam int ST_SLAVE_STALL_TX          = 9;
   localparam int ST_SLAVE_STALL_RX          = 10;
   localparam int ST_SDA_RECOVERED           = 11;

   // Control field positions.
   localparam int CTRL_ENABLE                = 0;
   localparam int CTRL_STALL_EN              = 1;

   // Event field positions, shared by event status and event mask.
   localparam int EV_MASTER_STALL_TX         = 0;
   localparam int EV_MASTER_STALL_RX         = 1;
   localparam int EV_SLAVE_STALL_TX          = 2;
   localparam int EV_SLAVE_STALL_RX          = 3;
   localparam int EV_ABORT_FLUSH             = 4;
   localparam int EV_W                       = 5;

   // APB slave phase.
   typedef enum logic [0:0] {
      APB_IDLE,
      APB_DONE
   } isf_apb_e;

endpackage : isf_pkg

// [isf_status_fifo_level.sv]
// Status reporting and queue level tracking for a two-wire bus controller.
// Assumes the controller core drives its FSM activity, queue push/pop pulses
// and abort signals synchronously to pclk, and an APB master reaches registers.
//
// Overview of operation
// - Slave stalls bus when receive queue overflows.
// - Slave stalls read while transmit queue empty.
// - Master stalls bus when receive queue overflows.
// - Master write stalls on empty, no stop.
// - Bit six shows slave FSM busy.
// - Bit five shows master FSM busy.
// - Bit zero is OR of both busy.
// - Bit four set while receive queue full.
// - Bit three set while receive queue nonempty.
// - Bit two set when transmit queue empty.
// - Bit one set while transmit queue has room.
// - Recovery bit shows data line was released.
// - Transmit count clears on disable or aborts.
// - Transmit count tracks pushes and pops.
// - Receive count clears on disable or transmit abort with nonzero cause.
// - Receive count tracks pushes and pops.
// - Disable forces bits one, two high; three, ten low.
// - Status register read-only, never interrupts.
`timescale 1ns/1ps
`default_nettype none

module isf_status_fifo_level (
   // Clock and reset.
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave port.
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   // Controller core state.
   input  wire logic                master_fsm_busy,
   input  wire logic                slave_fsm_busy,
   input  wire logic                master_write_active,
   input  wire logic                last_cmd_had_stop,
   input  wire logic                master_rx_byte_waiting,
   input  wire logic                slave_rx_byte_waiting,
   input  wire logic                slave_read_request,
   input  wire logic                sda_recovered,
   // Queue traffic pulses.
   input  wire logic                tx_push,
   input  wire logic                tx_pop,
   input  wire logic                rx_push,
   input  wire logic                rx_pop,
   // Abort signals.
   input  wire logic                transmit_abort_flag,
   input  wire logic [31:0]         abort_cause_record,
   input  wire logic                slave_bulk_abort,
   // Bus stall requests to the line drivers.
   output var  logic                master_stall_on_tx_empty,
   output var  logic                master_stall_on_rx_full,
   output var  logic                slave_stall_on_tx_empty,
   output var  logic                slave_stall_on_rx_full,
   // Interrupt.
   output var  logic                irq
);

   // Queue counts.
   logic [isf_pkg::COUNT_W-1:0]     tx_queue_count_q;     // Transmit entries held.
   logic [isf_pkg::COUNT_W-1:0]     rx_queue_count_q;     // Receive entries held.
   // Control and event registers.
   logic [1:0]                      ctrl_q;               // Enable and stall enable.
   logic [isf_pkg::EV_W-1:0]        event_q;              // Sticky events.
   logic [isf_pkg::EV_W-1:0]        mask_q;               // Event mask.
   // Stall flags, registered so they drop one cycle after their cause.
   logic                            mst_tx_q;
   logic                            mst_rx_q;
   logic                            slv_tx_q;
   logic                            slv_rx_q;
   // APB phase and outputs.
   isf_pkg::isf_apb_e               apb_q;
   logic [31:0]                     prdata_q;
   logic                            pslverr_q;
   logic                            irq_q;

   // Decoded helpers.
   logic                            enabled;              // Controller enabled.
   logic                            stall_en;             // Receive full stall enable.
   logic                            tx_empty;
   logic                            tx_full;
   logic                            rx_empty;
   logic                            rx_full;
   logic                            tx_clear;
   logic                            rx_clear;
   logic                            mst_tx_d;
   logic                            mst_rx_d;
   logic                            slv_tx_d;
   logic                            slv_rx_d;
   logic [31:0]                     status;               // Assembled bus status word.
   logic [isf_pkg::EV_W-1:0]        event_set;
   logic                            apb_access;           // Access phase, first cycle.
   logic                            apb_commit;           // Edge where pready is sampled high.
   logic                            wr_commit;
   logic                            addr_ok;
   logic [31:0]                     read_word;

   // Next queue count: a push into a full queue or a pop from an empty one is
   // ignored, so the count can never wrap past the depth.
   function automatic logic [isf_pkg::COUNT_W-1:0] next_count(
      input logic [isf_pkg::COUNT_W-1:0] cnt,
      input logic                        push,
      input logic                        pop);
      logic                              do_push;
      logic                              do_pop;
      do_push = push && (cnt != isf_pkg::QUEUE_DEPTH);
      do_pop  = pop && (cnt != '0);
      if (do_push && !do_pop) begin
         next_count = cnt + 3'h1;
      end else if (do_pop && !do_push) begin
         next_count = cnt - 3'h1;
      end else begin
         next_count = cnt;
      end
   endfunction

   // Word select for a register offset; used by decode and read mux.
   function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
      is_ofs = (a == ofs);
   endfunction

   assign enabled  = ctrl_q[isf_pkg::CTRL_ENABLE];
   assign stall_en = ctrl_q[isf_pkg::CTRL_STALL_EN];
   assign tx_empty = (tx_queue_count_q == '0);
   assign tx_full  = (tx_queue_count_q == isf_pkg::QUEUE_DEPTH);
   assign rx_empty = (rx_queue_count_q == '0);
   assign rx_full  = (rx_queue_count_q == isf_pkg::QUEUE_DEPTH);

   assign tx_clear = !enabled || transmit_abort_flag || slave_bulk_abort;
   assign rx_clear = !enabled || (transmit_abort_flag && (abort_cause_record != 32'h0000_0000));

   // Stall conditions; all are held off while the controller is disabled.
   always_comb begin
      mst_tx_d = enabled && master_write_active && tx_empty && !last_cmd_had_stop;
      mst_rx_d = enabled && stall_en && master_rx_byte_waiting && rx_full;
      slv_tx_d = enabled && slave_read_request && tx_empty;
      slv_rx_d = enabled && stall_en && slave_rx_byte_waiting && rx_full;
   end

   // Transmit queue level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_queue_count_q <= isf_pkg::LEVEL_RST[isf_pkg::COUNT_W-1:0];
      end else if (tx_clear) begin
         tx_queue_count_q <= '0;
      end else begin
         tx_queue_count_q <= next_count(tx_queue_count_q, tx_push, tx_pop);
      end
   end

   // Receive queue level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_queue_count_q <= isf_pkg::LEVEL_RST[isf_pkg::COUNT_W-1:0];
      end else if (rx_clear) begin
         rx_queue_count_q <= '0;
      end else begin
         rx_queue_count_q <= next_count(rx_queue_count_q, rx_push, rx_pop);
      end
   end

   // Stall flags follow their condition one cycle late, which is also what the
   // line drivers see; a combinational path would race the queue update.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mst_tx_q <= 1'b0;
         mst_rx_q <= 1'b0;
         slv_tx_q <= 1'b0;
         slv_rx_q <= 1'b0;
      end else begin
         mst_tx_q <= mst_tx_d;
         mst_rx_q <= mst_rx_d;
         slv_tx_q <= slv_tx_d;
         slv_rx_q <= slv_rx_d;
      end
   end

   // Bus status word assembly.
   always_comb begin
      status = 32'h0000_0000;
      status[isf_pkg::ST_SLAVE_BUSY]      = slave_fsm_busy;
      status[isf_pkg::ST_MASTER_BUSY]     = master_fsm_busy;
      status[isf_pkg::ST_ACTIVITY]        = master_fsm_busy || slave_fsm_busy;
      status[isf_pkg::ST_RX_FULL]         = rx_full;
      status[isf_pkg::ST_RX_NONEMPTY]     = !rx_empty;
      status[isf_pkg::ST_TX_EMPTY]        = tx_empty;
      status[isf_pkg::ST_TX_NOT_FULL]     = !tx_full;
      status[isf_pkg::ST_MASTER_STALL_TX] = mst_tx_q;
      status[isf_pkg::ST_MASTER_STALL_RX] = mst_rx_q;
      status[isf_pkg::ST_SLAVE_STALL_TX]  = slv_tx_q;
      status[isf_pkg::ST_SLAVE_STALL_RX]  = slv_rx_q;
      status[isf_pkg::ST_SDA_RECOVERED]   = sda_recovered;
      if (!enabled) begin
         status[isf_pkg::ST_TX_NOT_FULL]    = 1'b1;
         status[isf_pkg::ST_TX_EMPTY]       = 1'b1;
         status[isf_pkg::ST_RX_NONEMPTY]    = 1'b0;
         status[isf_pkg::ST_SLAVE_STALL_RX] = 1'b0;
      end
   end

   // Event sources: rising edges of each stall and any abort flush while enabled. The bus
   // status bits themselves never reach the interrupt line.
   always_comb begin
      event_set = '0;
      event_set[isf_pkg::EV_MASTER_STALL_TX] = mst_tx_d && !mst_tx_q;
      event_set[isf_pkg::EV_MASTER_STALL_RX] = mst_rx_d && !mst_rx_q;
      event_set[isf_pkg::EV_SLAVE_STALL_TX]  = slv_tx_d && !slv_tx_q;
      event_set[isf_pkg::EV_SLAVE_STALL_RX]  = slv_rx_d && !slv_rx_q;
      event_set[isf_pkg::EV_ABORT_FLUSH]     = enabled && (transmit_abort_flag || slave_bulk_abort);
   end

   // APB phase: one wait state, the answer comes on the second access cycle.
   assign apb_access = psel && penable && (apb_q == isf_pkg::APB_IDLE);
   assign apb_commit = psel && penable && (apb_q == isf_pkg::APB_DONE);

   // Address decode; anything else answers with an error.
   assign addr_ok = is_ofs(paddr, isf_pkg::BUS_STATUS_OFS) || is_ofs(paddr, isf_pkg::TX_LEVEL_OFS)
                 || is_ofs(paddr, isf_pkg::RX_LEVEL_OFS) || is_ofs(paddr, isf_pkg::CTRL_OFS)
                 || is_ofs(paddr, isf_pkg::EVENT_STATUS_OFS) || is_ofs(paddr, isf_pkg::EVENT_MASK_OFS);

   // Writes land only at the edge where pready is sampled high.
   assign wr_commit = apb_commit && pwrite && !pslverr_q;

   // Read multiplexer; reserved bits read as zero.
   always_comb begin
      read_word = 32'h0000_0000;
      if (is_ofs(paddr, isf_pkg::BUS_STATUS_OFS)) begin
         read_word = status;
      end else if (is_ofs(paddr, isf_pkg::TX_LEVEL_OFS)) begin
         read_word[isf_pkg::COUNT_W-1:0] = tx_queue_count_q;
      end else if (is_ofs(paddr, isf_pkg::RX_LEVEL_OFS)) begin
         read_word[isf_pkg::COUNT_W-1:0] = rx_queue_count_q;
      end else if (is_ofs(paddr, isf_pkg::CTRL_OFS)) begin
         read_word[1:0] = ctrl_q;
      end else if (is_ofs(paddr, isf_pkg::EVENT_STATUS_OFS)) begin
         read_word[isf_pkg::EV_W-1:0] = event_q;
      end else if (is_ofs(paddr, isf_pkg::EVENT_MASK_OFS)) begin
         read_word[isf_pkg::EV_W-1:0] = mask_q;
      end else begin
         read_word = 32'h0000_0000;
      end
   end

   // APB handshake and answer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_q     <= isf_pkg::APB_IDLE;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         case (apb_q)
            isf_pkg::APB_IDLE: begin
               if (apb_access) begin
                  apb_q    <= isf_pkg::APB_DONE;
                  prdata_q <= pwrite ? 32'h0000_0000 : read_word;
                  pslverr_q <= !addr_ok || (pwrite && (is_ofs(paddr, isf_pkg::BUS_STATUS_OFS)
                               || is_ofs(paddr, isf_pkg::TX_LEVEL_OFS)
                               || is_ofs(paddr, isf_pkg::RX_LEVEL_OFS)));
               end
            end
            isf_pkg::APB_DONE: begin
               apb_q     <= isf_pkg::APB_IDLE;
               prdata_q  <= 32'h0000_0000;
               pslverr_q <= 1'b0;
            end
            default: begin
               apb_q <= isf_pkg::APB_IDLE;
            end
         endcase
      end
   end

   // Control register: enable and receive full stall enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= isf_pkg::CTRL_RST;
      end else if (wr_commit && is_ofs(paddr, isf_pkg::CTRL_OFS)) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // Event mask register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= isf_pkg::EVENT_RST;
      end else if (wr_commit && is_ofs(paddr, isf_pkg::EVENT_MASK_OFS)) begin
         mask_q <= pwdata[isf_pkg::EV_W-1:0];
      end
   end

   // Sticky events, write one to clear; a new event in the clearing cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_q <= isf_pkg::EVENT_RST;
      end else if (wr_commit && is_ofs(paddr, isf_pkg::EVENT_STATUS_OFS)) begin
         event_q <= (event_q & ~pwdata[isf_pkg::EV_W-1:0]) | event_set;
      end else begin
         event_q <= event_q | event_set;
      end
   end

   // Level interrupt, one cycle behind the sticky bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(event_q & mask_q);
      end
   end

   assign prdata                   = prdata_q;
   assign pready                   = (apb_q == isf_pkg::APB_DONE);
   assign pslverr                  = pslverr_q;
   assign master_stall_on_tx_empty = mst_tx_q;
   assign master_stall_on_rx_full  = mst_rx_q;
   assign slave_stall_on_tx_empty  = slv_tx_q;
   assign slave_stall_on_rx_full   = slv_rx_q;
   assign irq                      = irq_q;

endmodule : isf_status_fifo_level
`default_nettype wire

// [isf_status_fifo_level_monitor.sv]
// Concurrent checks on the ports of the status and queue level block.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module isf_status_fifo_level_monitor (
   // Clock, reset and APB.
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Core state and stall outputs.
   input wire logic        master_fsm_busy,
   input wire logic        slave_fsm_busy,
   input wire logic        sda_recovered,
   input wire logic        last_cmd_had_stop,
   input wire logic        master_rx_byte_waiting,
   input wire logic        slave_rx_byte_waiting,
   input wire logic        slave_read_request,
   input wire logic        master_stall_on_tx_empty,
   input wire logic        master_stall_on_rx_full,
   input wire logic        slave_stall_on_tx_empty,
   input wire logic        slave_stall_on_rx_full
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic en_q; // Enable as committed over APB; the register is out of sight.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
      end else if (psel && penable && pready && pwrite && paddr == isf_pkg::CTRL_OFS) begin
         en_q <= pwdata[isf_pkg::CTRL_ENABLE];
      end
   end
   sequence s_cap;
      psel && penable && !pready && !pwrite && paddr == isf_pkg::BUS_STATUS_OFS;
   endsequence
   sequence s_rd_done;
      psel && penable && pready && !pwrite;
   endsequence
   property p_ready_wait;
      $rose(penable) && psel |-> !pready ##1 pready;
   endproperty
   property p_ro_err;
      psel && penable && pready && pwrite && paddr inside {8'h70, 8'h74, 8'h78} |-> pslverr;
   endproperty
   property p_activity;
      s_cap |=> pready && prdata[0] == ($past(master_fsm_busy) | $past(slave_fsm_busy))
         && prdata[5] == $past(master_fsm_busy) && prdata[6] == $past(slave_fsm_busy)
         && prdata[11] == $past(sda_recovered);
   endproperty
   property p_dis_status;
      s_rd_done and !en_q && paddr == isf_pkg::BUS_STATUS_OFS
         |-> prdata[2:1] == 2'h3 && !prdata[3] && !prdata[10];
   endproperty
   property p_dis_level;
      s_rd_done and !en_q && paddr inside {8'h74, 8'h78} |-> prdata == 32'h0;
   endproperty
   property p_slv_rx;
      !slave_rx_byte_waiting |=> !slave_stall_on_rx_full;
   endproperty
   property p_slv_tx;
      slave_stall_on_tx_empty |-> $past(slave_read_request);
   endproperty
   property p_mst_rx;
      !master_rx_byte_waiting [*2] |-> !master_stall_on_rx_full;
   endproperty
   property p_mst_tx;
      last_cmd_had_stop |=> !master_stall_on_tx_empty;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait.");
   a_ro_err: assert property (p_ro_err) else $error("Read-only write not refused.");
   a_activity: assert property (p_activity) else $error("Activity bits wrong.");
   a_dis_status: assert property (p_dis_status) else $error("Disabled status not forced.");
   a_dis_level: assert property (p_dis_level) else $error("Level not zero while disabled.");
   a_slv_rx: assert property (p_slv_rx) else $error("Slave rx stall stays on.");
   a_slv_tx: assert property (p_slv_tx) else $error("Slave tx stall without request.");
   a_mst_rx: assert property (p_mst_rx) else $error("Master rx stall stays on.");
   a_mst_tx: assert property (p_mst_tx) else $error("Master tx stall despite stop.");
endmodule // isf_status_fifo_level_monitor
`default_nettype wire

// [isf_core_model.sv]
// Far-side model: remote parties that fill the receive queue and drain the transmit one.
// Assumes the bench raises the request levels right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module isf_core_model (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Requests from the bench.
   input  wire logic send_en,
   input  wire logic take_en,
   input  wire logic slow,
   // Queue traffic toward the block.
   output var  logic rx_push,
   output var  logic tx_pop
);
   logic ph_q; // Slow parties move a byte every other cycle.
   // One byte per one-cycle pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q    <= 1'b0;
         rx_push <= 1'b0;
         tx_pop  <= 1'b0;
      end else begin
         ph_q    <= !ph_q;
         rx_push <= send_en && (!slow || ph_q);
         tx_pop  <= take_en && (!slow || ph_q);
      end
   end
endmodule // isf_core_model
`default_nettype wire

// [test_i2c_status_fifo_level.sv]
// Self-checking bench for the status and queue level block, with an integer model.
// Assumes the package constants and a one-wait-state APB slave.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_status_fifo_level;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, abort_cause_record, rd, x;
   logic master_fsm_busy, slave_fsm_busy, master_write_active, last_cmd_had_stop, sda_recovered;
   logic master_rx_byte_waiting, slave_rx_byte_waiting, slave_read_request;
   logic tx_push, tx_pop, rx_push, rx_pop, transmit_abort_flag, slave_bulk_abort;
   logic master_stall_on_tx_empty, master_stall_on_rx_full, slave_stall_on_tx_empty, slave_stall_on_rx_full;
   logic send_en, take_en, slow, en_m, sten; // Far-side requests and modelled control bits.
   logic [15:0] lf;                          // Random source.
   int num_errors, n_checks, txc, rxc, cyc;
   localparam int DEPTH = isf_pkg::QUEUE_DEPTH;
   isf_status_fifo_level u_dut (.*);
   isf_core_model u_far (.*);
   always #50 pclk = ~pclk;
   // Queue model: clears first, then pushes and pops within the bounds.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         report_and_stop;
      end
      if (!en_m || transmit_abort_flag || slave_bulk_abort) txc = 0;
      else txc = txc + (tx_push && txc < DEPTH) - (tx_pop && txc > 0);
      if (!en_m || (transmit_abort_flag && abort_cause_record != 0)) rxc = 0;
      else rxc = rxc + (rx_push && rxc < DEPTH) - (rx_pop && rxc > 0);
   end
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Expected status from the model and present input levels.
   function automatic logic [31:0] exp_st();
      logic [31:0] s;
      s = 32'h0;
      s[0] = master_fsm_busy | slave_fsm_busy;
      s[5] = master_fsm_busy;
      s[6] = slave_fsm_busy;
      s[11] = sda_recovered;
      s[1] = !en_m || txc != DEPTH;
      s[2] = !en_m || txc == 0;
      if (en_m) begin
         s[3] = rxc != 0;
         s[4] = rxc == DEPTH;
         s[7] = master_write_active && !last_cmd_had_stop && txc == 0;
         s[8] = sten && rxc == DEPTH && master_rx_byte_waiting;
         s[9] = slave_read_request && txc == 0;
         s[10] = sten && rxc == DEPTH && slave_rx_byte_waiting;
      end
      return s;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
            output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] ex, input logic ee);
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, ex);
      chk(32'(er), 32'(ee));
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      apb(1'b1, a, d, rd, er);
      chk(32'(er), 32'(ee));
   endtask
   // Status read, expectation taken once fresh inputs settled, then stalls.
   task st_chk;
      apb(1'b0, isf_pkg::BUS_STATUS_OFS, 32'h0, rd, er);
      x = exp_st();
      chk(rd, x);
      chk(32'(er), 32'h0);
      chk({28'h0, master_stall_on_tx_empty, master_stall_on_rx_full, slave_stall_on_tx_empty,
           slave_stall_on_rx_full}, {28'h0, x[7], x[8], x[9], x[10]});
   endtask
   task pulse_tx(input int n);
      @(posedge pclk);
      tx_push <= 1'b1;
      repeat (n) @(posedge pclk);
      tx_push <= 1'b0;
   endtask
   task report_and_stop;
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {pclk, psel, penable, pwrite, paddr, pwdata, abort_cause_record, presetn} = '0;
      {master_fsm_busy, slave_fsm_busy, master_write_active, last_cmd_had_stop, sda_recovered} = '0;
      {master_rx_byte_waiting, slave_rx_byte_waiting, slave_read_request, tx_push, rx_pop} = '0;
      {transmit_abort_flag, slave_bulk_abort, send_en, take_en, slow, en_m, sten} = '0;
      lf = 16'h0060;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      st_chk;
      rdchk(isf_pkg::TX_LEVEL_OFS, 0, 1'b0);
      rdchk(isf_pkg::RX_LEVEL_OFS, 0, 1'b0);
      rdchk(8'ha0, 0, 1'b1);
      wr(isf_pkg::TX_LEVEL_OFS, 32'h5, 1'b1);
      pulse_tx(2);
      rdchk(isf_pkg::TX_LEVEL_OFS, 0, 1'b0);
      wr(isf_pkg::CTRL_OFS, 32'h3, 1'b0);
      en_m <= 1'b1;
      sten <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         {master_fsm_busy, slave_fsm_busy, sda_recovered} <= i[2:0];
         st_chk;
      end
      slave_read_request <= 1'b1;
      master_write_active <= 1'b1;
      st_chk;
      pulse_tx(5);
      st_chk;
      rdchk(isf_pkg::TX_LEVEL_OFS, txc, 1'b0);
      {slave_rx_byte_waiting, master_rx_byte_waiting, send_en, slow} <= 4'hf;
      repeat (12) @(posedge pclk);
      send_en <= 1'b0;
      st_chk;
      rdchk(isf_pkg::RX_LEVEL_OFS, rxc, 1'b0);
      @(posedge pclk);
      rx_pop <= 1'b1;
      @(posedge pclk);
      rx_pop <= 1'b0;
      {slave_read_request, master_write_active, slave_rx_byte_waiting, master_rx_byte_waiting} <= 4'h0;
      st_chk;
      rdchk(isf_pkg::EVENT_STATUS_OFS, 32'hf, 1'b0);
      wr(isf_pkg::EVENT_MASK_OFS, 32'hf, 1'b0);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      wr(isf_pkg::EVENT_STATUS_OFS, 32'hf, 1'b0);
      rdchk(isf_pkg::EVENT_STATUS_OFS, 32'h0, 1'b0);
      chk(32'(irq), 32'h0);
      @(posedge pclk);
      transmit_abort_flag <= 1'b1;
      @(posedge pclk);
      transmit_abort_flag <= 1'b0;
      rdchk(isf_pkg::TX_LEVEL_OFS, 0, 1'b0);
      rdchk(isf_pkg::RX_LEVEL_OFS, rxc, 1'b0);
      @(posedge pclk);
      {transmit_abort_flag, abort_cause_record} <= {1'b1, 32'h0002_0000};
      @(posedge pclk);
      transmit_abort_flag <= 1'b0;
      rdchk(isf_pkg::RX_LEVEL_OFS, 0, 1'b0);
      pulse_tx(2);
      slave_bulk_abort <= 1'b1;
      @(posedge pclk);
      slave_bulk_abort <= 1'b0;
      rdchk(isf_pkg::TX_LEVEL_OFS, 0, 1'b0);
      rdchk(isf_pkg::EVENT_STATUS_OFS, 32'h10, 1'b0);
      chk(32'(irq), 32'h0);
      for (int i = 0; i < 24; i++) begin
         lf = nx(lf);
         @(posedge pclk);
         {tx_push, rx_pop, send_en, take_en, slow} <= lf[4:0];
         {master_fsm_busy, slave_fsm_busy, slave_read_request, master_write_active} <= lf[8:5];
         {last_cmd_had_stop, slave_rx_byte_waiting, master_rx_byte_waiting} <= lf[11:9];
         transmit_abort_flag <= lf[12] & lf[13];
         abort_cause_record <= {31'h0, lf[14]};
         @(posedge pclk);
         {tx_push, rx_pop, send_en, take_en, transmit_abort_flag} <= 5'h0;
         st_chk;
         rdchk(isf_pkg::TX_LEVEL_OFS, txc, 1'b0);
         rdchk(isf_pkg::RX_LEVEL_OFS, rxc, 1'b0);
      end
      wr(isf_pkg::CTRL_OFS, 32'h2, 1'b0);
      en_m <= 1'b0;
      st_chk;
      rdchk(isf_pkg::TX_LEVEL_OFS, 0, 1'b0);
      rdchk(isf_pkg::RX_LEVEL_OFS, 0, 1'b0);
      report_and_stop;
   end
endmodule // test_i2c_status_fifo_level
bind isf_status_fifo_level isf_status_fifo_level_monitor u_mon (.*);
`default_nettype wire
